// ===== src/pups_top.sv
// Behaviour
// RULE_01: software-writable select bits choose the pull-up for each implemented pin
// RULE_02: each pin's pull-up is on only when select is set and pin inputs
// RULE_03: output-mode pins never get a pull-up, whatever the select bit says
// RULE_04: pins driving an alternate-function output never get a pull-up
// RULE_05: select registers take both single-bit and whole-byte writes
// RULE_06: reset clears every select register to zero, no pull-up connected
// RULE_07: select bit 0 means disconnected, 1 means pull-up requested
// RULE_08: small variant: port1 bits 0-3, port3 bits 1,2,5, port12 bit 0
// RULE_09: 36-pin variant adds port0 bits 0 and 1; the code also adds port3 bits 3 and 4 (port3 mask 8'h3e)
// RULE_10: unimplemented bits read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none

module pups_top
	import pups_pkg::*;
#(
	parameter pups_variant_e VARIANT = PUPS_VAR_36PIN
) (
	// clock and reset
	input  wire logic            ref_clk,
	input  wire logic            rst_b,
	// cpu memory access
	input  wire pups_cpu_req_s   cpu_req,
	output var  logic [7:0]      rdata_ff,
	output var  logic            rvalid_ff,
	// pin conditions from the port-mode and alternate-function logic
	input  wire pups_port_bank_s pin_input_mode,
	input  wire pups_port_bank_s pin_altfn_out,
	// pull-up enables toward the pads
	output var  pups_port_bank_s pullup_en_ff
);

	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------
	pups_reg_e       hit;
	pups_port_bank_s sel;
	pups_port_bank_s pull_comb;
	pups_port_bank_s nxt_pullup_en;
	logic [7:0]      nxt_rdata;
	logic            nxt_rvalid;

	localparam logic [7:0] MASK_P0  = pups_impl_mask(VARIANT, PUPS_REG_PORT0);  // RULE_09
	localparam logic [7:0] MASK_P1  = pups_impl_mask(VARIANT, PUPS_REG_PORT1);  // RULE_08
	localparam logic [7:0] MASK_P3  = pups_impl_mask(VARIANT, PUPS_REG_PORT3);  // RULE_08
	localparam logic [7:0] MASK_P12 = pups_impl_mask(VARIANT, PUPS_REG_PORT12); // RULE_08

	always_comb begin
		hit = pups_decode(cpu_req.addr);
	end

	// ---------------------------------------------------------------
	// selection registers
	// ---------------------------------------------------------------
	// port0 exists only on the larger part; its mask is empty otherwise
	pups_sel_reg #(
		.IMPL_MASK (MASK_P0)
	) u_sel_port0 (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.wr_byte (cpu_req.wr_byte && (hit == PUPS_REG_PORT0)), // RULE_01
		.wr_bit  (cpu_req.wr_bit && (hit == PUPS_REG_PORT0)),
		.bit_idx (cpu_req.bit_idx),
		.bit_val (cpu_req.bit_val),
		.wdata   (cpu_req.wdata),
		.sel_ff  (sel.port0)
	);

	pups_sel_reg #(
		.IMPL_MASK (MASK_P1)
	) u_sel_port1 (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.wr_byte (cpu_req.wr_byte && (hit == PUPS_REG_PORT1)), // RULE_01
		.wr_bit  (cpu_req.wr_bit && (hit == PUPS_REG_PORT1)),
		.bit_idx (cpu_req.bit_idx),
		.bit_val (cpu_req.bit_val),
		.wdata   (cpu_req.wdata),
		.sel_ff  (sel.port1)
	);

	pups_sel_reg #(
		.IMPL_MASK (MASK_P3)
	) u_sel_port3 (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.wr_byte (cpu_req.wr_byte && (hit == PUPS_REG_PORT3)), // RULE_01
		.wr_bit  (cpu_req.wr_bit && (hit == PUPS_REG_PORT3)),
		.bit_idx (cpu_req.bit_idx),
		.bit_val (cpu_req.bit_val),
		.wdata   (cpu_req.wdata),
		.sel_ff  (sel.port3)
	);

	pups_sel_reg #(
		.IMPL_MASK (MASK_P12)
	) u_sel_port12 (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.wr_byte (cpu_req.wr_byte && (hit == PUPS_REG_PORT12)), // RULE_01
		.wr_bit  (cpu_req.wr_bit && (hit == PUPS_REG_PORT12)),
		.bit_idx (cpu_req.bit_idx),
		.bit_val (cpu_req.bit_val),
		.wdata   (cpu_req.wdata),
		.sel_ff  (sel.port12)
	);

	// ---------------------------------------------------------------
	// pull-up gating
	// ---------------------------------------------------------------
	pups_pull_gate u_gate_port0 (
		.sel        (sel.port0),
		.input_mode (pin_input_mode.port0),
		.altfn_out  (pin_altfn_out.port0),
		.pull_en    (pull_comb.port0)
	);

	pups_pull_gate u_gate_port1 (
		.sel        (sel.port1),
		.input_mode (pin_input_mode.port1),
		.altfn_out  (pin_altfn_out.port1),
		.pull_en    (pull_comb.port1)
	);

	pups_pull_gate u_gate_port3 (
		.sel        (sel.port3),
		.input_mode (pin_input_mode.port3),
		.altfn_out  (pin_altfn_out.port3),
		.pull_en    (pull_comb.port3)
	);

	pups_pull_gate u_gate_port12 (
		.sel        (sel.port12),
		.input_mode (pin_input_mode.port12),
		.altfn_out  (pin_altfn_out.port12),
		.pull_en    (pull_comb.port12)
	);

	// ---------------------------------------------------------------
	// read path and pad enables
	// ---------------------------------------------------------------
	// unimplemented bits are already zero in the stored value
	always_comb begin
		nxt_rvalid = cpu_req.rd;
		nxt_rdata  = rdata_ff;
		if (cpu_req.rd) begin
			if (hit == PUPS_REG_PORT0) begin
				nxt_rdata = sel.port0; // RULE_10
			end else if (hit == PUPS_REG_PORT1) begin
				nxt_rdata = sel.port1;
			end else if (hit == PUPS_REG_PORT3) begin
				nxt_rdata = sel.port3;
			end else if (hit == PUPS_REG_PORT12) begin
				nxt_rdata = sel.port12;
			end else begin
				nxt_rdata = PUPS_READ_NONE;
			end
		end
		// registered so pads see a glitch-free enable; costs one cycle
		nxt_pullup_en = pull_comb; // RULE_02
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_ff     <= PUPS_READ_NONE;
			rvalid_ff    <= 1'b0;
			pullup_en_ff <= '0; // RULE_06
		end else begin
			rdata_ff     <= nxt_rdata;
			rvalid_ff    <= nxt_rvalid;
			pullup_en_ff <= nxt_pullup_en;
		end
	end

endmodule

`default_nettype wire

// ===== include/pups_pkg.sv
`default_nettype none

package pups_pkg;

	// ---------------------------------------------------------------
	// register addresses in the cpu memory space
	// ---------------------------------------------------------------
	localparam logic [15:0] PUPS_ADDR_PORT0  = 16'hff30;
	localparam logic [15:0] PUPS_ADDR_PORT1  = 16'hff31;
	localparam logic [15:0] PUPS_ADDR_PORT3  = 16'hff33;
	localparam logic [15:0] PUPS_ADDR_PORT12 = 16'hff3c;

	localparam logic [7:0]  PUPS_RESET_VAL   = 8'h00;
	localparam logic [7:0]  PUPS_READ_NONE   = 8'h00;

	// ---------------------------------------------------------------
	// implemented bits per register and per package variant
	// ---------------------------------------------------------------
	localparam logic [7:0]  PUPS_MASK_P0_SMALL  = 8'h00;
	localparam logic [7:0]  PUPS_MASK_P1_SMALL  = 8'h0f;
	localparam logic [7:0]  PUPS_MASK_P3_SMALL  = 8'h26;
	localparam logic [7:0]  PUPS_MASK_P12_SMALL = 8'h01;
	localparam logic [7:0]  PUPS_MASK_P0_36PIN  = 8'h03;
	localparam logic [7:0]  PUPS_MASK_P1_36PIN  = 8'h0f;
	localparam logic [7:0]  PUPS_MASK_P3_36PIN  = 8'h3e;
	localparam logic [7:0]  PUPS_MASK_P12_36PIN = 8'h01;

	typedef enum logic {
		PUPS_VAR_SMALL,
		PUPS_VAR_36PIN
	} pups_variant_e;

	typedef enum logic [2:0] {
		PUPS_REG_PORT0,
		PUPS_REG_PORT1,
		PUPS_REG_PORT3,
		PUPS_REG_PORT12,
		PUPS_REG_NONE
	} pups_reg_e;

	// one cpu memory access, byte-wise or bit-wise
	typedef struct packed {
		logic [15:0] addr;
		logic        wr_byte;
		logic        wr_bit;
		logic [2:0]  bit_idx;
		logic        bit_val;
		logic [7:0]  wdata;
		logic        rd;
	} pups_cpu_req_s;

	// one byte per pull-up capable port
	typedef struct packed {
		logic [7:0] port0;
		logic [7:0] port1;
		logic [7:0] port3;
		logic [7:0] port12;
	} pups_port_bank_s;

	function automatic pups_reg_e pups_decode(input logic [15:0] addr);
		pups_reg_e r;
		r = PUPS_REG_NONE;
		if (addr == PUPS_ADDR_PORT0) begin
			r = PUPS_REG_PORT0;
		end else if (addr == PUPS_ADDR_PORT1) begin
			r = PUPS_REG_PORT1;
		end else if (addr == PUPS_ADDR_PORT3) begin
			r = PUPS_REG_PORT3;
		end else if (addr == PUPS_ADDR_PORT12) begin
			r = PUPS_REG_PORT12;
		end
		return r;
	endfunction

	function automatic logic [7:0] pups_impl_mask(input pups_variant_e v, input pups_reg_e r);
		logic [7:0] m;
		m = 8'h00;
		case (r)
			PUPS_REG_PORT0: begin
				m = (v == PUPS_VAR_36PIN) ? PUPS_MASK_P0_36PIN : PUPS_MASK_P0_SMALL;
			end
			PUPS_REG_PORT1: begin
				m = (v == PUPS_VAR_36PIN) ? PUPS_MASK_P1_36PIN : PUPS_MASK_P1_SMALL;
			end
			PUPS_REG_PORT3: begin
				m = (v == PUPS_VAR_36PIN) ? PUPS_MASK_P3_36PIN : PUPS_MASK_P3_SMALL;
			end
			PUPS_REG_PORT12: begin
				m = (v == PUPS_VAR_36PIN) ? PUPS_MASK_P12_36PIN : PUPS_MASK_P12_SMALL;
			end
			default: begin
				m = 8'h00;
			end
		endcase
		return m;
	endfunction

endpackage

`default_nettype wire

// ===== src/pups_sel_reg.sv
`timescale 1ns/1ps
`default_nettype none

module pups_sel_reg
	import pups_pkg::*;
#(
	parameter logic [7:0] IMPL_MASK = 8'hff
) (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	// write access, already decoded for this register
	input  wire logic       wr_byte,
	input  wire logic       wr_bit,
	input  wire logic [2:0] bit_idx,
	input  wire logic       bit_val,
	input  wire logic [7:0] wdata,
	// stored selection
	output var  logic [7:0] sel_ff
);

	logic [7:0] nxt_sel;
	logic [7:0] bit_upd;

	// ---------------------------------------------------------------
	// next value
	// ---------------------------------------------------------------
	always_comb begin
		bit_upd = sel_ff;
		bit_upd[bit_idx] = bit_val;
		nxt_sel = sel_ff;
		if (wr_byte) begin
			nxt_sel = wdata & IMPL_MASK; // RULE_05 RULE_10
		end else if (wr_bit) begin
			// only the addressed bit moves, neighbours keep their value
			nxt_sel = bit_upd & IMPL_MASK; // RULE_05 RULE_10
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sel_ff <= PUPS_RESET_VAL; // RULE_06
		end else begin
			sel_ff <= nxt_sel;
		end
	end

endmodule

`default_nettype wire

// ===== src/pups_pull_gate.sv
`timescale 1ns/1ps
`default_nettype none

module pups_pull_gate
	import pups_pkg::*;
(
	// per-pin conditions
	input  wire logic [7:0] sel,
	input  wire logic [7:0] input_mode,
	input  wire logic [7:0] altfn_out,
	// pull-up request
	output var  logic [7:0] pull_en
);

	// ---------------------------------------------------------------
	// per-pin gating
	// ---------------------------------------------------------------
	always_comb begin
		// a 0 select bit never connects; output or alt-fn output pins veto it
		pull_en = sel & input_mode & ~altfn_out; // RULE_02 RULE_03 RULE_04 RULE_07
	end

endmodule

`default_nettype wire

// ===== dv/pups_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module pups_top_assertions
	import pups_pkg::*;
#(
	parameter pups_variant_e VARIANT = PUPS_VAR_36PIN
) (
	// clock and reset
	input wire logic            ref_clk,
	input wire logic            rst_b,
	// register access
	input wire pups_cpu_req_s   cpu_req,
	input wire logic [7:0]      rdata_ff,
	input wire logic            rvalid_ff,
	// pins
	input wire pups_port_bank_s pin_input_mode,
	input wire pups_port_bank_s pin_altfn_out,
	input wire pups_port_bank_s pullup_en_ff
);
	localparam logic [31:0] PIN_MASK = (VARIANT == PUPS_VAR_36PIN) ? 32'h030f3e01 : 32'h000f2601;

	function automatic logic [7:0] amask(input logic [15:0] a);
		case (a)
			PUPS_ADDR_PORT0: return PIN_MASK[31:24];
			PUPS_ADDR_PORT1: return PIN_MASK[23:16];
			PUPS_ADDR_PORT3: return PIN_MASK[15:8];
			PUPS_ADDR_PORT12: return PIN_MASK[7:0];
			default: return 8'h00;
		endcase
	endfunction

	function automatic logic mbit(input logic [15:0] a, input logic [2:0] i);
		logic [7:0] m;
		m = amask(a);
		return m[i];
	endfunction

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	// ---------------------------------------------
	// write then read back the same address
	// ---------------------------------------------
	sequence s_byte_rd;
		cpu_req.wr_byte ##1 cpu_req.rd && $stable(cpu_req.addr);
	endsequence
	sequence s_bit_rd;
		cpu_req.wr_bit && !cpu_req.wr_byte ##1 cpu_req.rd && $stable(cpu_req.addr);
	endsequence

	chk_byte_write: assert property (s_byte_rd |=> rdata_ff ==
		($past(cpu_req.wdata, 2) & amask($past(cpu_req.addr, 2)))) else $error("byte write lost");
	chk_bit_write: assert property (s_bit_rd |=> rdata_ff[$past(cpu_req.bit_idx, 2)] ==
		($past(cpu_req.bit_val, 2) & mbit($past(cpu_req.addr, 2), $past(cpu_req.bit_idx, 2))))
		else $error("bit write lost");
	chk_read_masked: assert property (rvalid_ff |->
		(rdata_ff & ~amask($past(cpu_req.addr))) == 8'h00) else $error("unimplemented bit read");
	chk_rvalid_pulse: assert property (cpu_req.rd |=> rvalid_ff) else $error("read not answered");
	chk_rvalid_cause: assert property (rvalid_ff |-> $past(cpu_req.rd)) else $error("stray rvalid");
	chk_pull_input: assert property ((pullup_en_ff & ~$past(pin_input_mode)) == 32'h0)
		else $error("pull-up on output pin");
	chk_pull_altfn: assert property ((pullup_en_ff & $past(pin_altfn_out)) == 32'h0)
		else $error("pull-up on altfn pin");
	chk_unimpl_pins: assert property ((pullup_en_ff & ~PIN_MASK) == 32'h0)
		else $error("pull-up on missing pin");
	chk_reset_clear: assert property (disable iff (1'b0) !rst_b |=>
		pullup_en_ff == 32'h0 && !rvalid_ff && rdata_ff == 8'h00) else $error("reset not clear");
endmodule

bind pups_top pups_top_assertions #(.VARIANT(VARIANT)) u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
	.cpu_req(cpu_req), .rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff), .pin_input_mode(pin_input_mode),
	.pin_altfn_out(pin_altfn_out), .pullup_en_ff(pullup_en_ff));

`default_nettype wire

// ===== dv/port_pullup_select_test.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end

module port_pullup_select_test;
	import pups_pkg::*;
	logic            ref_clk = 1'b0;
	logic            rst_b = 1'b0;
	pups_cpu_req_s   cpu_req = '0;
	logic [7:0]      rdata_ff;
	logic            rvalid_ff;
	pups_port_bank_s pin_input_mode = '0;
	pups_port_bank_s pin_altfn_out = '0;
	pups_port_bank_s pullup_en_ff;
	int              errors = 0;
	int              checks = 0;
	logic [15:0]     addrs [4] = '{16'hff30, 16'hff31, 16'hff33, 16'hff3c};
	logic [7:0]      masks [4] = '{8'h03, 8'h0f, 8'h3e, 8'h01};
	logic [7:0]      smasks [4] = '{8'h00, 8'h0f, 8'h26, 8'h01};
	logic [7:0]      rdata_small;
	logic            rvalid_small;
	pups_port_bank_s pullup_small;

	always #10 ref_clk = ~ref_clk;

	pups_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .cpu_req(cpu_req), .rdata_ff(rdata_ff),
		.rvalid_ff(rvalid_ff), .pin_input_mode(pin_input_mode), .pin_altfn_out(pin_altfn_out),
		.pullup_en_ff(pullup_en_ff));

	// small part shares the bus and pins, only its masks differ
	pups_top #(.VARIANT(PUPS_VAR_SMALL)) dut_small (.ref_clk(ref_clk), .rst_b(rst_b),
		.cpu_req(cpu_req), .rdata_ff(rdata_small), .rvalid_ff(rvalid_small),
		.pin_input_mode(pin_input_mode), .pin_altfn_out(pin_altfn_out),
		.pullup_en_ff(pullup_small));

	// ---------------------------------------------
	// access tasks, driven 1 ns after the edge
	// ---------------------------------------------
	// request stays up until the next call replaces it, one assignment per step
	task automatic acc(input pups_cpu_req_s r);
		cpu_req = r;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic wbyte(input logic [15:0] a, input logic [7:0] d);
		acc({a, 1'b1, 1'b0, 3'h0, 1'b0, d, 1'b0});
	endtask
	task automatic wbit(input logic [15:0] a, input logic [2:0] i, input logic v);
		acc({a, 1'b0, 1'b1, i, v, 8'h00, 1'b0});
	endtask
	task automatic rchk(input logic [15:0] a, input logic [7:0] e);
		acc({a, 1'b0, 1'b0, 3'h0, 1'b0, 8'h00, 1'b1});
		`CHK(rvalid_ff, 1'b1)
		`CHK(rdata_ff, e)
	endtask
	// one edge registers the pad enables
	task automatic pins(input logic [31:0] m, input logic [31:0] f, input logic [31:0] e);
		cpu_req = '0;
		pin_input_mode = m;
		pin_altfn_out = f;
		@(posedge ref_clk);
		#1;
		`CHK(pullup_en_ff, e)
	endtask
	task automatic summarize();
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		#20000;
		errors++;
		summarize();
	end

	initial begin
		repeat (4) @(posedge ref_clk);
		#1;
		rst_b = 1'b1;
		`CHK(pullup_en_ff, 32'h0)
		`CHK(pullup_small, 32'h0)
		for (int i = 0; i < 4; i++) begin
			rchk(addrs[i], 8'h00);
			wbyte(addrs[i], 8'hff);
			rchk(addrs[i], masks[i]);
			`CHK(rdata_small, smasks[i])
		end
		wbyte(16'hff32, 8'hff);
		rchk(16'hff32, 8'h00);
		pins(32'hffffffff, 32'h0, 32'h030f3e01);
		`CHK(pullup_small, 32'h000f2601)
		pins(32'h0, 32'h0, 32'h0);
		pins(32'hffffffff, 32'hffffffff, 32'h0);
		pins(32'h0005ff00, 32'h00010400, 32'h00043a00);
		wbyte(16'hff33, 8'h00);
		wbit(16'hff33, 3'h5, 1'b1);
		wbit(16'hff33, 3'h0, 1'b1);
		rchk(16'hff33, 8'h20);
		pins(32'hffffffff, 32'h0, 32'h030f2001);
		wbit(16'hff3c, 3'h0, 1'b0);
		rchk(16'hff3c, 8'h00);
		pins(32'hffffffff, 32'h0, 32'h030f2000);
		// byte write must win over a bit write in the same cycle
		acc({16'hff31, 1'b1, 1'b1, 3'h0, 1'b1, 8'h0a, 1'b0});
		rchk(16'hff31, 8'h0a);
		rst_b = 1'b0;
		@(posedge ref_clk);
		#1;
		rst_b = 1'b1;
		`CHK(pullup_en_ff, 32'h0)
		rchk(16'hff31, 8'h00);
		summarize();
	end
endmodule

`default_nettype wire
